// *** dctr_regs.sv ***
// setup_control and action_strobe registers with lock, nonvolatile handshake and waveform
// assumes a serial decoder on i_clk_sys giving one-cycle write/read strobes
`timescale 1ns/10ps
module dctr_regs
   import dctr_pkg::*;
#(
   parameter int unsigned P_SLOW_BASE_CYC = SLOW_BASE_CYC
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // register access
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_rdata,
   // code sources
   input wire logic [9:0] i_dac_data,
   input wire logic [9:0] i_margin_high,
   input wire logic [9:0] i_margin_low,
   // nonvolatile memory
   output logic o_nvm_recall_req,
   output logic o_nvm_store_req,
   output logic [15:0] o_nvm_store_data,
   input wire logic i_nvm_done,
   input wire logic [15:0] i_nvm_recall_data,
   output logic o_nonvolatile_in_progress,
   // converter controls
   output logic [9:0] o_dac_code,
   output logic o_output_enable,
   output logic o_pull_10k,
   output logic o_high_impedance,
   output logic o_ref_internal,
   output logic [1:0] o_output_gain_select,
   output logic o_gain_applied,
   output logic o_device_locked,
   output logic o_defaults_load
);
   logic [15:0] setup;
   logic waveform_run;
   logic margin_high_go;
   logic margin_low_go;
   logic nonvolatile_recall;
   logic nonvolatile_store;
   dctr_wave_t wave_state;
   dctr_wave_t next_wave_state;
   logic wave_load;
   logic [9:0] wave_load_code;

   wire locked = setup[LOCK_BIT];
   wire busy = nonvolatile_recall | nonvolatile_store;
   wire [1:0] waveform_shape = setup[SHAPE_LSB +: 2];
   wire [1:0] output_powerdown_mode = setup[PDN_LSB +: 2];
   wire [3:0] soft_restart_field = i_wdata[3:0];

   // decode
   wire setup_hit = i_wr_en && (i_addr == SETUP_OFS);
   wire trig_wr = i_wr_en && (i_addr == TRIG_OFS); // R14
   wire setup_wr = setup_hit && !locked && !busy; // R16 R15
   wire unlock_hit = trig_wr && (i_wdata[UNLOCK_LSB +: 4] == UNLOCK_CODE); // R6 R18
   wire trig_act = trig_wr && !locked && !busy; // R16 R15
   wire cfg_reset = trig_act && i_wdata[CFG_RESET_BIT]; // R7
   wire soft_go = trig_act && (soft_restart_field == SOFT_GO); // R13
   wire to_defaults = cfg_reset || soft_go;
   wire recall_start = (trig_act && i_wdata[RECALL_BIT]) || soft_go; // R11 R13
   wire store_start = trig_act && i_wdata[STORE_BIT] && !recall_start; // R12
   wire nvm_finish = busy && i_nvm_done;

   // ramp target: margin high wins, then margin low, then waveform, then data
   wire [9:0] wave_target = (wave_state == DCTR_WV_UP) ? i_margin_high : i_margin_low;
   wire [9:0] ramp_target = margin_high_go ? i_margin_high :
                            margin_low_go ? i_margin_low :
                            waveform_run ? wave_target : i_dac_data;
   wire wave_active = waveform_run && !margin_high_go && !margin_low_go;
   wire at_target;
   wire tick;
   wire mhigh_done = margin_high_go && at_target; // R9
   wire mlow_done = margin_low_go && !margin_high_go && at_target; // R10

   // setup_control
   wire [15:0] next_setup = to_defaults ? SETUP_RESET : // R7 R13
                            (nonvolatile_recall && i_nvm_done) ?
                               (i_nvm_recall_data & ~(16'h1 << LOCK_BIT)) : // R11
                            setup_wr ? i_wdata : // R16
                            unlock_hit ? (setup & ~(16'h1 << LOCK_BIT)) : setup; // R6

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         setup <= SETUP_RESET; // R1 R2 R3 R4
      else
         setup <= next_setup;
   end

   // action_strobe held and self-clearing bits
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n || to_defaults)
      begin
         waveform_run <= 1'b0;
         margin_high_go <= 1'b0;
         margin_low_go <= 1'b0;
      end
      else if (trig_act)
      begin
         // a write of 1 wins over the self-clear in the same cycle
         waveform_run <= i_wdata[RUN_BIT]; // R8
         margin_high_go <= i_wdata[MHIGH_BIT] || (margin_high_go && !mhigh_done); // R9
         margin_low_go <= i_wdata[MLOW_BIT] || (margin_low_go && !mlow_done); // R10
      end
      else
      begin
         margin_high_go <= margin_high_go && !mhigh_done; // R9 R18
         margin_low_go <= margin_low_go && !mlow_done; // R10 R18
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         nonvolatile_recall <= 1'b0;
         nonvolatile_store <= 1'b0;
      end
      else
      begin
         nonvolatile_recall <= recall_start || (nonvolatile_recall && !i_nvm_done); // R11
         nonvolatile_store <= store_start || (nonvolatile_store && !i_nvm_done); // R12
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         o_defaults_load <= 1'b0;
      else
         o_defaults_load <= to_defaults; // R7 R13
   end

   // read-back: write-only fields read 0, the restart field its idle code
   wire [15:0] trig_view = {4'h0, 2'h0, 1'b0, waveform_run, margin_high_go, margin_low_go,
                            nonvolatile_recall, nonvolatile_store, SOFT_IDLE}; // R14 R18
   wire [15:0] rd_mux = (i_addr == SETUP_OFS) ? (setup & ~(16'h1 << LOCK_BIT)) :
                        (i_addr == TRIG_OFS) ? trig_view : 16'h0000;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         o_rdata <= 16'h0000;
      else if (i_rd_en)
         o_rdata <= rd_mux;
   end

   // waveform sequencer
   always_comb
   begin
      next_wave_state = wave_state;
      wave_load = 1'b0;
      wave_load_code = i_margin_low;
      case (wave_state)
         DCTR_WV_IDLE:
         begin
            if (wave_active)
               next_wave_state = DCTR_WV_UP; // R8
         end
         DCTR_WV_UP:
         begin
            if (!wave_active)
               next_wave_state = DCTR_WV_IDLE; // R8
            else if (waveform_shape == SHAPE_TRI)
            begin
               if (at_target)
                  next_wave_state = DCTR_WV_DOWN; // R17
            end
            else if (waveform_shape == SHAPE_SAW_UP)
               wave_load = at_target; // R17
            else if (waveform_shape == SHAPE_SAW_DN)
               next_wave_state = DCTR_WV_DOWN; // R17
            else if (tick)
            begin
               wave_load = 1'b1; // R17
               next_wave_state = DCTR_WV_DOWN;
            end
         end
         DCTR_WV_DOWN:
         begin
            wave_load_code = i_margin_high;
            if (!wave_active)
               next_wave_state = DCTR_WV_IDLE; // R8
            else if (waveform_shape == SHAPE_TRI)
            begin
               if (at_target)
                  next_wave_state = DCTR_WV_UP; // R17
            end
            else if (waveform_shape == SHAPE_SAW_DN)
               wave_load = at_target; // R17
            else if (waveform_shape == SHAPE_SAW_UP)
               next_wave_state = DCTR_WV_UP; // R17
            else if (tick)
            begin
               wave_load = 1'b1; // R17
               next_wave_state = DCTR_WV_UP;
            end
         end
         default:
            next_wave_state = DCTR_WV_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         wave_state <= DCTR_WV_IDLE;
      else
         wave_state <= next_wave_state;
   end

   dctr_ramp #(
      .P_SLOW_BASE_CYC(P_SLOW_BASE_CYC)
   ) u_ramp (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_code_step(setup[STEP_LSB +: 3]),
      .i_slew_rate(setup[SLEW_LSB +: 4]),
      .i_target(ramp_target),
      .i_load(wave_load),
      .i_load_code(wave_load_code),
      .o_code(o_dac_code),
      .o_at_target(at_target),
      .o_tick(tick)
   );

   // converter controls
   assign o_output_enable = (output_powerdown_mode == PDN_UP); // R3
   assign o_high_impedance = (output_powerdown_mode == PDN_HIZ); // R3
   assign o_pull_10k = output_powerdown_mode[0]; // R3
   assign o_ref_internal = setup[REF_BIT]; // R4
   // gain is meaningless on the supply reference, so it is flagged rather than forced
   assign o_gain_applied = setup[REF_BIT]; // R5
   assign o_output_gain_select = setup[SPAN_LSB +: 2]; // R5
   assign o_device_locked = locked;
   assign o_nonvolatile_in_progress = busy; // R15
   assign o_nvm_recall_req = nonvolatile_recall;
   assign o_nvm_store_req = nonvolatile_store;
   assign o_nvm_store_data = setup & ~(16'h1 << LOCK_BIT);

   default clocking dctr_cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   chk_unlock_clears: assert property (unlock_hit |=> !o_device_locked) // R6
      else $error("unlock code left device locked");
   chk_lock_holds: assert property (locked && i_wr_en && !unlock_hit |=> $stable(setup)) // R16
      else $error("locked setup changed");
   chk_cfg_defaults: assert property (cfg_reset |=> // R7
      setup == SETUP_RESET && !waveform_run && o_defaults_load)
      else $error("config reset did not restore defaults");
   chk_run_follows: assert property (trig_act && !to_defaults |=> // R8
      waveform_run == $past(i_wdata[RUN_BIT]))
      else $error("run bit did not follow write");
   chk_mhigh_clear: assert property (mhigh_done && !trig_act |=> !margin_high_go) // R9
      else $error("margin high bit did not self-clear");
   chk_mlow_clear: assert property (mlow_done && !trig_act |=> !margin_low_go) // R10
      else $error("margin low bit did not self-clear");
   chk_recall_busy: assert property (recall_start && !i_nvm_done |=> // R11
      o_nonvolatile_in_progress && o_nvm_recall_req ##1 !i_nvm_done |-> o_nvm_recall_req)
      else $error("recall not held busy");
   chk_store_busy: assert property (store_start |=> o_nvm_store_req && !o_nvm_recall_req) // R12
      else $error("store did not start");
   chk_soft_restart: assert property (soft_go |=> setup == SETUP_RESET && o_nvm_recall_req) // R13
      else $error("soft restart incomplete");
   chk_trig_read: assert property (i_rd_en && i_addr == TRIG_OFS |=> // R14
      o_rdata[3:0] == SOFT_IDLE && o_rdata[15:9] == 7'h00)
      else $error("action register read wrong");
   chk_busy_refuse: assert property (busy && setup_hit && !i_nvm_done |=> $stable(setup)) // R15
      else $error("setup written while busy");
   // a refused trigger write must leave run as it was; a wrong-code trigger write must leave the lock set
   chk_busy_trig: assert property (busy && trig_wr |=> $stable(waveform_run)) // R15
      else $error("trigger acted while busy");
   chk_unlock_other: assert property ( // R18
      locked && trig_wr && i_wdata[UNLOCK_LSB +: 4] != UNLOCK_CODE |=> o_device_locked)
      else $error("wrong unlock code cleared the lock");
   chk_pdn_onehot: assert property ( // R3
      $countones({o_output_enable, o_pull_10k, o_high_impedance}) == 1)
      else $error("power-down decode not one-hot");
   chk_recall_apply: assert property ( // R11
      nvm_finish && nonvolatile_recall |=> !busy &&
         setup == ($past(i_nvm_recall_data) & ~(16'h1 << LOCK_BIT)))
      else $error("recalled word not applied");
   chk_saw_reload: assert property ( // R17
      wave_active && waveform_shape == SHAPE_SAW_UP && wave_state == DCTR_WV_UP && at_target
      |=> o_dac_code == $past(i_margin_low))
      else $error("rising saw did not fall to low margin");

   cov_recall: cover property (recall_start ##[1:50] nvm_finish);
   cov_margin: cover property (margin_high_go ##[1:1000] !margin_high_go);
   cov_unlock: cover property (locked ##[1:20] unlock_hit);
   cov_wave: cover property (wave_state == DCTR_WV_UP ##[1:1000] wave_state == DCTR_WV_DOWN);
   cov_saw: cover property (wave_load && waveform_shape == SHAPE_SAW_UP);
endmodule // dctr_regs

// *** dctr_pkg.sv ***
// constants shared by the configuration/trigger register block and its slew engine
// assumes one 25 MHz system clock and register writes from a serial decoder on that clock
//
// What this block does
// [R1] code step size field 000..111 selects 1,2,3,4,6,8,16,32 LSB; resets to 000
// [R2] step wait from 4-bit field: base time times 1, 1.25, 1.5, 1.75; resets 1111
// [R3] power-down 00 up, 01/11 down with 10K to ground, 10 high-z; resets 10
// [R4] reference bit 0 selects supply, 1 selects internal 1.21 V; resets 0
// [R5] gain field 1.5X/2X/3X/4X applies only while internal reference enabled
// [R6] writing 0101 to trigger bits 15:12 clears the lock
// [R7] trigger bit 9 written 1 reloads all registers with factory defaults
// [R8] trigger bit 8 high runs continuous waveform generation, low stops it
// [R9] bit 7 ramps code to upper margin, clears itself when code reaches it
// [R10] bit 6 ramps code to lower margin, clears itself when code reaches it
// [R11] bit 5 recalls nonvolatile values, busy flag high meanwhile, bit self-clears
// [R12] bit 4 stores settings to nonvolatile memory, busy flag high, bit self-clears
// [R13] soft restart 1010 recalls from nonvolatile memory, defaults elsewhere; idle 1000
// [R14] trigger register at D3h, reset value 0008h
// [R15] busy flag shown while nonvolatile work runs; writes to converter registers refused
// [R16] lock bit 13 of setup register locks all registers until unlock code
// [R17] 2-bit waveform shape: triangle, rising saw, falling saw, square
// [R18] self-clearing bits read 0 when done; other unlock values leave lock unchanged
package dctr_pkg;
   // register offsets
   localparam logic [7:0] SETUP_OFS = 8'hD1;
   localparam logic [7:0] TRIG_OFS = 8'hD3;
   // reset values
   localparam logic [15:0] SETUP_RESET = 16'h01F0;
   localparam logic [15:0] TRIG_RESET = 16'h0008;
   // setup_control field positions
   localparam int SHAPE_LSB = 14;
   localparam int LOCK_BIT = 13;
   localparam int PMBUS_BIT = 12;
   localparam int STEP_LSB = 9;
   localparam int SLEW_LSB = 5;
   localparam int PDN_LSB = 3;
   localparam int REF_BIT = 2;
   localparam int SPAN_LSB = 0;
   // action_strobe field positions and codes
   localparam int UNLOCK_LSB = 12;
   localparam int CFG_RESET_BIT = 9;
   localparam int RUN_BIT = 8;
   localparam int MHIGH_BIT = 7;
   localparam int MLOW_BIT = 6;
   localparam int RECALL_BIT = 5;
   localparam int STORE_BIT = 4;
   localparam logic [3:0] UNLOCK_CODE = 4'h5;
   localparam logic [3:0] SOFT_GO = 4'hA;
   localparam logic [3:0] SOFT_IDLE = 4'h8;
   // power-down codes
   localparam logic [1:0] PDN_UP = 2'h0;
   localparam logic [1:0] PDN_HIZ = 2'h2;
   // waveform shapes
   localparam logic [1:0] SHAPE_TRI = 2'h0;
   localparam logic [1:0] SHAPE_SAW_UP = 2'h1;
   localparam logic [1:0] SHAPE_SAW_DN = 2'h2;
   // step sizes in LSB, indexed by the step field
   localparam logic [7:0][5:0] STEP_LUT = {6'h20, 6'h10, 6'h08, 6'h06,
                                           6'h04, 6'h03, 6'h02, 6'h01};
   // step times in ps, as printed, and the clock period
   localparam int unsigned CLK_PERIOD_PS = 40000;
   localparam int unsigned FAST_BASE_PS = 25600000;
   localparam int unsigned SLOW_BASE_PS = 204800000;
   localparam int unsigned MICRO_BASE_PS = 1638400;
   // least times, rounded up to whole cycles
   localparam int unsigned FAST_BASE_CYC = (FAST_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned SLOW_BASE_CYC = (SLOW_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned MICRO_BASE_CYC = (MICRO_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // waveform sequencer
   typedef enum logic [2:0]
   {
      DCTR_WV_IDLE = 3'h1,
      DCTR_WV_UP = 3'h2,
      DCTR_WV_DOWN = 3'h4
   } dctr_wave_t;
endpackage

// *** dctr_ramp.sv ***
// slew engine: steps the output code toward a target at the programmed size and rate
// assumes target and load come from logic on the same clock
`timescale 1ns/10ps
module dctr_ramp
   import dctr_pkg::*;
#(
   parameter int unsigned P_SLOW_BASE_CYC = SLOW_BASE_CYC
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // slew settings
   input wire logic [2:0] i_code_step,
   input wire logic [3:0] i_slew_rate,
   // target and immediate load
   input wire logic [9:0] i_target,
   input wire logic i_load,
   input wire logic [9:0] i_load_code,
   // state
   output logic [9:0] o_code,
   output logic o_at_target,
   output logic o_tick
);
   logic [16:0] cnt;
   wire [15:0] base_cyc = (i_slew_rate[3:2] == 2'h0) ? 16'(FAST_BASE_CYC) :
                          (i_slew_rate[3:2] == 2'h1) ? 16'(P_SLOW_BASE_CYC) :
                          16'(MICRO_BASE_CYC);
   // codes 11xx fall back on the shortest base
   wire [18:0] scaled = 19'(base_cyc) * 19'(3'h4 + {1'b0, i_slew_rate[1:0]}) + 19'h3; // R2
   wire [16:0] wait_cyc = scaled[18:2];
   wire [9:0] step = {4'h0, STEP_LUT[i_code_step]}; // R1
   wire [9:0] up_gap = i_target - o_code;
   wire [9:0] dn_gap = o_code - i_target;
   wire [9:0] next_code = (o_code < i_target) ? ((up_gap <= step) ? i_target : o_code + step) :
                          ((dn_gap <= step) ? i_target : o_code - step); // R1

   // compare with >= so a shortened rate takes effect at once
   assign o_tick = (cnt >= wait_cyc - 17'h1); // R2
   assign o_at_target = (o_code == i_target);

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n || o_tick)
         cnt <= 17'h0;
      else
         cnt <= cnt + 17'h1;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         o_code <= 10'h000;
      else if (i_load)
         o_code <= i_load_code;
      else if (o_tick && !o_at_target)
         o_code <= next_code;
   end

   chk_step_bounded: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R1
      !$past(i_load) && $past(i_reset_n) && o_code > $past(o_code) |->
         o_code - $past(o_code) <= 10'($past(step)))
      else $error("code rose by more than one step");
   chk_tick_spacing: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R2
      o_tick && $stable(i_slew_rate) |=> !o_tick)
      else $error("step ticks came back to back");
endmodule // dctr_ramp

// *** dctr_nvm_model.sv ***
// nonvolatile memory stand-in answering recall and store requests
// assumes level requests from the register block on the same clock
`timescale 1ns/10ps
module dctr_nvm_model
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // request side
   input wire logic i_recall_req,
   input wire logic i_store_req,
   input wire logic [15:0] i_store_data,
   input wire logic [7:0] i_delay,
   // answer side
   output logic o_done,
   output logic [15:0] o_recall_data
);
   logic [15:0] stored;
   logic [7:0] count;
   logic armed;
   wire req = i_recall_req | i_store_req;
   // word shown only with done; its inverse otherwise, so an early sample shows up
   assign o_recall_data = o_done ? stored : ~stored;
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         stored <= 16'h0000;
         count <= 8'h00;
         armed <= 1'b1;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (!req)
         begin
            armed <= 1'b1;
            count <= 8'h00;
         end
         else if (armed && count >= i_delay)
         begin
            // one answer per request; re-armed only once the request drops
            o_done <= 1'b1;
            armed <= 1'b0;
            if (i_store_req)
               stored <= i_store_data;
         end
         else if (armed)
            count <= count + 8'h01;
      end
   end
endmodule // dctr_nvm_model

// *** testbench.sv ***
// register-level tests of the configuration and trigger block
// assumes the nonvolatile stand-in on the far side and a 25 MHz clock
`timescale 1ns/10ps
`define CHK(what, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("mismatch %s expected %h seen %h", what, exp, got); \
      end \
   end
module testbench
   import dctr_pkg::*;
;
   int n_mismatch, n_checks;
   logic clk_sys, reset_n, wr_en, rd_en, nvm_done;
   logic [7:0] addr, delay;
   logic [15:0] wdata, rdata, store_data, recall_data;
   logic [9:0] dac_data, m_high, m_low, code;
   logic recall_req, store_req, busy, oen, pull, hiz, ref_int, gain_on, locked, dflt;
   logic [1:0] gain_sel;
   int n;
   logic hit;
   logic [9:0] c0;
   int steps[8] = '{1, 2, 3, 4, 6, 8, 16, 32};
   logic [3:0] rc[4] = '{4'h0, 4'h5, 4'hA, 4'hD};
   int rw[4] = '{640, 80, 62, 52};
   // short slow base keeps the 01xx rates cheap to run
   dctr_regs #(.P_SLOW_BASE_CYC(64)) u_dctr_regs (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
      .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
      .i_dac_data(dac_data), .i_margin_high(m_high), .i_margin_low(m_low),
      .o_nvm_recall_req(recall_req), .o_nvm_store_req(store_req), .o_nvm_store_data(store_data),
      .i_nvm_done(nvm_done), .i_nvm_recall_data(recall_data), .o_nonvolatile_in_progress(busy),
      .o_dac_code(code), .o_output_enable(oen), .o_pull_10k(pull), .o_high_impedance(hiz),
      .o_ref_internal(ref_int), .o_output_gain_select(gain_sel), .o_gain_applied(gain_on),
      .o_device_locked(locked), .o_defaults_load(dflt));
   dctr_nvm_model u_dctr_nvm_model (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
      .i_recall_req(recall_req), .i_store_req(store_req), .i_store_data(store_data),
      .i_delay(delay), .o_done(nvm_done), .o_recall_data(recall_data));
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string nm);
      rd(a);
      `CHK(nm, e, rdata)
   endtask
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask
   // cycles until the output code next moves, capped
   task automatic wait_move(output int k);
      logic [9:0] c;
      c = code;
      k = 0;
      while (code === c && k < 3000)
      begin
         tick();
         k++;
      end
   endtask
   task automatic reach(input logic [9:0] v, output logic h);
      h = 1'b0;
      for (int k = 0; k < 3000 && !h; k++)
      begin
         tick();
         h = (code === v);
      end
   endtask
   // polls the trigger register until the given bit drops, capped
   // reads at least once, so a bit seen clear by an earlier poll cannot end this one early
   task automatic poll_clear(input int b);
      int k;
      k = 0;
      do
      begin
         rd(TRIG_OFS);
         k++;
      end
      while (rdata[b] !== 1'b0 && k < 400);
      `CHK("poll bit clear", 1'b0, rdata[b])
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 500 && busy !== 1'b0; k++)
         tick();
      `CHK("busy cleared", 1'b0, busy)
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clk_sys);
      n_mismatch++;
      wrap_up();
   end
   initial
   begin
      n_mismatch = 0;
      n_checks = 0;
      reset_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      dac_data = 10'h000;
      m_high = 10'h000;
      m_low = 10'h000;
      delay = 8'h14;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      tick();
      `CHK("hiz at reset", 1'b1, hiz)
      rd_chk(SETUP_OFS, 16'h01F0, "setup reset");
      rd_chk(TRIG_OFS, 16'h0008, "trigger reset");
      rd_chk(8'hD2, 16'h0000, "unmapped");
      for (int k = 0; k < 4; k++)
      begin
         wr(SETUP_OFS, 16'(16'h01E0 | (k << 3)));
         `CHK("enable", k == 0, oen)
         `CHK("pull", k[0], pull)
         `CHK("hiz", k == 2, hiz)
      end
      wr(SETUP_OFS, 16'h01E7);
      `CHK("ref", 1'b1, ref_int)
      `CHK("gain on", 1'b1, gain_on)
      `CHK("gain", 2'h3, gain_sel)
      wr(SETUP_OFS, 16'h01E2);
      `CHK("ref off", 1'b0, ref_int)
      `CHK("gain off", 1'b0, gain_on)
      rd_chk(SETUP_OFS, 16'h01E2, "setup readback");
      @(posedge clk_sys);
      dac_data <= 10'h3FF;
      for (int s = 0; s < 8; s++)
      begin
         wr(SETUP_OFS, 16'(s * 512 + 256));
         wait_move(n);
         c0 = code;
         wait_move(n);
         `CHK("step", 10'(steps[s]), 10'(code - c0))
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(SETUP_OFS, 16'({rc[i], 5'h00}));
         wait_move(n);
         wait_move(n);
         `CHK("step wait", rw[i], n)
      end
      @(posedge clk_sys);
      dac_data <= 10'd200;
      m_high <= 10'd300;
      m_low <= 10'd100;
      wr(SETUP_OFS, 16'h0F00);
      wr(TRIG_OFS, 16'h0088);
      rd_chk(TRIG_OFS, 16'h0088, "margin high set");
      poll_clear(MHIGH_BIT);
      `CHK("at high margin", 10'd300, code)
      `CHK("high bit cleared", 16'h0008, rdata)
      wr(TRIG_OFS, 16'h0048);
      poll_clear(MLOW_BIT);
      `CHK("at low margin", 10'd100, code)
      wr(TRIG_OFS, 16'h0108);
      rd_chk(TRIG_OFS, 16'h0108, "run bit");
      reach(10'd300, hit);
      `CHK("wave high", 1'b1, hit)
      reach(10'd100, hit);
      `CHK("wave low", 1'b1, hit)
      wr(TRIG_OFS, 16'h0008);
      reach(10'd200, hit);
      repeat (200) tick();
      `CHK("wave stopped", 10'd200, code)
      wr(SETUP_OFS, 16'h4F00);
      wr(TRIG_OFS, 16'h0108);
      reach(10'd300, hit);
      tick();
      `CHK("saw up drop", 10'd100, code)
      wr(SETUP_OFS, 16'hCF00);
      reach(10'd100, hit);
      wait_move(n);
      `CHK("square jump", 10'd300, code)
      wr(SETUP_OFS, 16'h8F00);
      reach(10'd100, hit);
      tick();
      `CHK("saw down rise", 10'd300, code)
      wr(TRIG_OFS, 16'h0008);
      wr(SETUP_OFS, 16'h4A5D);
      wr(TRIG_OFS, 16'h0018);
      `CHK("store req", 1'b1, store_req)
      `CHK("busy", 1'b1, busy)
      `CHK("store data", 16'h4A5D, store_data)
      rd_chk(TRIG_OFS, 16'h0018, "store bit");
      wr(SETUP_OFS, 16'h01F0);
      wr(TRIG_OFS, 16'h0108);
      wait_idle();
      rd_chk(SETUP_OFS, 16'h4A5D, "write while busy");
      rd_chk(TRIG_OFS, 16'h0008, "store bit cleared");
      wr(SETUP_OFS, 16'h0000);
      wr(TRIG_OFS, 16'h0028);
      `CHK("recall req", 1'b1, recall_req)
      `CHK("busy recall", 1'b1, busy)
      wait_idle();
      rd_chk(SETUP_OFS, 16'h4A5D, "recalled");
      rd_chk(TRIG_OFS, 16'h0008, "recall bit cleared");
      delay <= 8'h00;
      wr(SETUP_OFS, 16'h0100);
      wr(TRIG_OFS, 16'h000A);
      `CHK("restart recall", 1'b1, recall_req)
      `CHK("restart defaults", 1'b1, dflt)
      wait_idle();
      rd_chk(SETUP_OFS, 16'h4A5D, "restart recalled");
      rd_chk(TRIG_OFS, 16'h0008, "soft idle");
      wr(TRIG_OFS, 16'h0208);
      `CHK("config defaults", 1'b1, dflt)
      rd_chk(SETUP_OFS, 16'h01F0, "config reset");
      wr(SETUP_OFS, 16'h21E0);
      `CHK("locked", 1'b1, locked)
      wr(SETUP_OFS, 16'h01E8);
      `CHK("locked pdn", 1'b1, oen)
      wr(TRIG_OFS, 16'h3008);
      `CHK("wrong code", 1'b1, locked)
      wr(TRIG_OFS, 16'h0018);
      `CHK("locked trigger", 1'b0, store_req)
      wr(TRIG_OFS, 16'h5008);
      `CHK("unlocked", 1'b0, locked)
      wr(SETUP_OFS, 16'h01E8);
      `CHK("pull after unlock", 1'b1, pull)
      wrap_up();
   end
endmodule // testbench
